// >>> wor_option_regs.sv
// write-once option registers with wishbone classic slave
// assumes por is high during power-on reset together with rst
//
// Function
// R1: each option word accepts one software write per reset, held until reset
// R2: word two at 0x1e, word one at 0x1f, both always readable
// R3: word one bits 7..0 hold rate, stop-monitor, monitor controls, recovery, stop, dog
// R4: any reset clears word one except voltage mode; power-on clears all
// R5: reset-pin enable cleared only by power-on reset
// R6: outside stop, rate bit picks 8176 or 262128 cycle watchdog timeout
// R7: in stop, rate bit picks 512 or 16384 wakeup oscillator cycles
// R8: short recovery bit picks 32 or 4096 cycle stop exit delay
// R9: stop exit from monitor reset always uses the long delay
// R10: stop enable clear makes the stop instruction an illegal opcode
// R11: watchdog disable bit set turns the watchdog off
// R12: monitor runs in stop only when in-stop set and power-disable clear
// R13: monitor reset disable blocks monitor resets
// R14: monitor power disable powers the monitor down
// R15: voltage mode bit picks 5-V trip when set, 3-V when clear
// R16: two-bit oscillator field selects internal, external, rc or crystal
// R17: interrupt-pin function bit enables the interrupt input
// R18: interrupt pullup bit set disconnects the pullup
// R19: software should write the options right after reset
// R20: each word has its own lock; later writes ignored silently
// R21: field positions in word two are implementer chosen
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps

module wor_option_regs
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        por,
  input  wire logic        in_stop,
  input  wire logic        wake_by_monitor,
  input  wire logic        monitor_reset_req,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [17:0] watchdog_timeout,
  output logic      [14:0] wakeup_period,
  output logic      [12:0] stop_recovery,
  output logic             stop_illegal,
  output logic             watchdog_enable,
  output logic             monitor_on,
  output logic             monitor_reset,
  output logic             monitor_5v_mode,
  output logic      [1:0]  osc_select,
  output logic             int_pin_function_on,
  output logic             int_pin_pullup_on,
  output logic             reset_pin_function_on
);

  // ********************************
  // bus decode
  // ********************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  logic [7:0] word_one_q;
  logic [7:0] word_two_q;
  logic       lock_one_q;
  logic       lock_two_q;
  logic       req;
  logic       wr_lane0;
  logic       wr_one;
  logic       wr_two;

  assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_lane0 = req && wb_we_i && wb_sel_i[0];

  // write strobes per option word, lock state not yet applied
  assign wr_one   = wr_lane0 && hit(wb_adr_i, wor_pkg::OPT_ONE_ADDR);
  assign wr_two   = wr_lane0 && hit(wb_adr_i, wor_pkg::OPT_TWO_ADDR);

  always_ff @(posedge core_clk)
  begin
    if (rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  // ********************************
  // write-once locks
  // ********************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      lock_one_q <= 1'b0;
      lock_two_q <= 1'b0;
    end
    else
    begin
      if (wr_one)
        lock_one_q <= 1'b1; // see R20
      if (wr_two)
        lock_two_q <= 1'b1; // see R20
    end
  end

  // ********************************
  // option word one
  // ********************************
  always_ff @(posedge core_clk)
  begin
    if (rst && por)
      word_one_q <= wor_pkg::OPT_ONE_RESET; // see R4
    else if (rst)
    begin
      word_one_q <= wor_pkg::OPT_ONE_RESET; // see R4
      word_one_q[wor_pkg::MON_VMODE_BIT] <= word_one_q[wor_pkg::MON_VMODE_BIT];
    end
    else if (wr_one && !lock_one_q)
      word_one_q <= wb_dat_i[7:0]; // see R1 // see R3
  end

  // ********************************
  // option word two
  // ********************************
  always_ff @(posedge core_clk)
  begin
    if (rst && por)
      word_two_q <= wor_pkg::OPT_TWO_RESET; // see R5
    else if (rst)
    begin
      word_two_q <= wor_pkg::OPT_TWO_RESET;
      word_two_q[wor_pkg::RST_FUNC_ON_BIT] <= word_two_q[wor_pkg::RST_FUNC_ON_BIT]; // see R5
    end
    else if (wr_two && !lock_two_q)
      word_two_q <= wb_dat_i[7:0]; // see R1 // see R21
  end

  // ********************************
  // read data
  // ********************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
      wb_dat_o <= 32'h0000_0000;
    else if (req && !wb_we_i)
    begin
      if (hit(wb_adr_i, wor_pkg::OPT_ONE_ADDR))
        wb_dat_o <= {24'h00_0000, word_one_q}; // see R2
      else if (hit(wb_adr_i, wor_pkg::OPT_TWO_ADDR))
        wb_dat_o <= {24'h00_0000, word_two_q}; // see R2
      else if (hit(wb_adr_i, wor_pkg::STAT_ADDR))
        wb_dat_o <= {30'h0000_0000, lock_two_q, lock_one_q};
      else
        wb_dat_o <= 32'h0000_0000;
    end
  end

  // ********************************
  // option outputs
  // ********************************
  // timing counts: the counting itself lives outside this block
  always_ff @(posedge core_clk)
  begin
    if (rst)
      watchdog_timeout <= wor_pkg::WDOG_LONG_CYC;
    else
      watchdog_timeout <= word_one_q[wor_pkg::WDOG_RATE_BIT] ?
                          wor_pkg::WDOG_SHORT_CYC : wor_pkg::WDOG_LONG_CYC; // see R6
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      wakeup_period <= wor_pkg::WAKE_LONG_CYC;
    else
      wakeup_period <= word_one_q[wor_pkg::WDOG_RATE_BIT] ?
                       wor_pkg::WAKE_SHORT_CYC : wor_pkg::WAKE_LONG_CYC; // see R7
  end

  // a monitor-caused wake never gets the short delay
  always_ff @(posedge core_clk)
  begin
    if (rst)
      stop_recovery <= wor_pkg::REC_LONG_CYC;
    else if (word_one_q[wor_pkg::SHORT_REC_BIT] && !wake_by_monitor)
      stop_recovery <= wor_pkg::REC_SHORT_CYC; // see R8
    else
      stop_recovery <= wor_pkg::REC_LONG_CYC; // see R9
  end

  // ********************************
  // option enables
  // ********************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
      stop_illegal <= 1'b1;
    else
      stop_illegal <= !word_one_q[wor_pkg::STOP_EN_BIT]; // see R10
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      watchdog_enable <= 1'b1;
    else
      watchdog_enable <= !word_one_q[wor_pkg::WDOG_DIS_BIT]; // see R11
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      monitor_on <= 1'b1;
    else
      monitor_on <= !word_one_q[wor_pkg::MON_PWR_DIS_BIT] &&
                    (!in_stop || word_one_q[wor_pkg::MON_IN_STOP_BIT]); // see R12 // see R14
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      monitor_reset <= 1'b0;
    else
      monitor_reset <= monitor_reset_req && !word_one_q[wor_pkg::MON_RST_DIS_BIT]; // see R13
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      monitor_5v_mode <= 1'b0;
    else
      monitor_5v_mode <= word_one_q[wor_pkg::MON_VMODE_BIT]; // see R15
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      osc_select <= 2'h0;
    else
      osc_select <= {word_two_q[wor_pkg::OSC_HIGH_BIT],
                     word_two_q[wor_pkg::OSC_LOW_BIT]}; // see R16
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      int_pin_function_on <= 1'b0;
    else
      int_pin_function_on <= word_two_q[wor_pkg::INT_FUNC_ON_BIT]; // see R17
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      int_pin_pullup_on <= 1'b1;
    else
      int_pin_pullup_on <= !word_two_q[wor_pkg::INT_PULLUP_OFF_BIT]; // see R18
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      reset_pin_function_on <= 1'b0;
    else
      reset_pin_function_on <= word_two_q[wor_pkg::RST_FUNC_ON_BIT]; // see R5
  end

  // ********************************
  // checks
  // ********************************
  a_lock_holds_one: assert property (@(posedge core_clk) disable iff (rst)
    lock_one_q |=> $stable(word_one_q)) // see R1
    else $error("word one changed after lock");

  a_lock_holds_two: assert property (@(posedge core_clk) disable iff (rst)
    lock_two_q |=> $stable(word_two_q)) // see R20
    else $error("word two changed after lock");

  a_read_one: assert property (@(posedge core_clk) disable iff (rst)
    req && !wb_we_i && hit(wb_adr_i, wor_pkg::OPT_ONE_ADDR)
      |=> wb_dat_o[7:0] == $past(word_one_q)) // see R2
    else $error("word one read mismatch");

  a_vmode_kept: assert property (@(posedge core_clk)
    rst && !por |=> word_one_q[wor_pkg::MON_VMODE_BIT] ==
      $past(word_one_q[wor_pkg::MON_VMODE_BIT])) // see R4
    else $error("voltage mode lost on warm reset");

  a_rstpin_kept: assert property (@(posedge core_clk)
    rst && !por |=> word_two_q[wor_pkg::RST_FUNC_ON_BIT] ==
      $past(word_two_q[wor_pkg::RST_FUNC_ON_BIT])) // see R5
    else $error("reset pin enable lost on warm reset");

  a_por_clears: assert property (@(posedge core_clk)
    rst && por |=> word_one_q == 8'h00 && word_two_q == 8'h00) // see R4
    else $error("power-on reset left bits set");

  a_recovery_sel: assert property (@(posedge core_clk) disable iff (rst)
    wake_by_monitor |=> stop_recovery == wor_pkg::REC_LONG_CYC) // see R9
    else $error("monitor wake used short recovery");

  a_rate_sel: assert property (@(posedge core_clk) disable iff (rst)
    word_one_q[wor_pkg::WDOG_RATE_BIT] ##1 $stable(word_one_q)
      |-> watchdog_timeout == wor_pkg::WDOG_SHORT_CYC) // see R6
    else $error("watchdog rate wrong");

  a_stop_illegal: assert property (@(posedge core_clk) disable iff (rst)
    !word_one_q[wor_pkg::STOP_EN_BIT] |=> stop_illegal) // see R10
    else $error("stop allowed while disabled");

  a_mon_reset: assert property (@(posedge core_clk) disable iff (rst)
    word_one_q[wor_pkg::MON_RST_DIS_BIT] |=> !monitor_reset) // see R13
    else $error("monitor reset not blocked");

  a_mon_reset_pass: assert property (@(posedge core_clk) disable iff (rst)
    monitor_reset_req && !word_one_q[wor_pkg::MON_RST_DIS_BIT] |=> monitor_reset) // see R13
    else $error("monitor reset not passed");

  a_first_write: assert property (@(posedge core_clk) disable iff (rst)
    wr_one && !lock_one_q |=> word_one_q == $past(wb_dat_i[7:0])) // see R1
    else $error("first write to word one lost");

  a_lock_sets: assert property (@(posedge core_clk) disable iff (rst)
    wr_two |=> lock_two_q) // see R20
    else $error("word two lock not set");

  a_ack_pulse: assert property (@(posedge core_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o) // see R2
    else $error("ack longer than one cycle");

  a_wdog_long: assert property (@(posedge core_clk) disable iff (rst)
    !word_one_q[wor_pkg::WDOG_RATE_BIT] |=> watchdog_timeout == wor_pkg::WDOG_LONG_CYC) // see R6
    else $error("watchdog long rate wrong");

  a_wake_short: assert property (@(posedge core_clk) disable iff (rst)
    word_one_q[wor_pkg::WDOG_RATE_BIT] |=> wakeup_period == wor_pkg::WAKE_SHORT_CYC) // see R7
    else $error("short wakeup period wrong");

  a_wake_long: assert property (@(posedge core_clk) disable iff (rst)
    !word_one_q[wor_pkg::WDOG_RATE_BIT] |=> wakeup_period == wor_pkg::WAKE_LONG_CYC) // see R7
    else $error("long wakeup period wrong");

  a_recovery_short: assert property (@(posedge core_clk) disable iff (rst)
    word_one_q[wor_pkg::SHORT_REC_BIT] && !wake_by_monitor
      |=> stop_recovery == wor_pkg::REC_SHORT_CYC) // see R8
    else $error("short recovery not used");

  a_stop_legal: assert property (@(posedge core_clk) disable iff (rst)
    word_one_q[wor_pkg::STOP_EN_BIT] |=> !stop_illegal) // see R10
    else $error("stop refused while enabled");

  a_wdog_off: assert property (@(posedge core_clk) disable iff (rst)
    word_one_q[wor_pkg::WDOG_DIS_BIT] |=> !watchdog_enable) // see R11
    else $error("watchdog not disabled");

  a_wdog_on: assert property (@(posedge core_clk) disable iff (rst)
    !word_one_q[wor_pkg::WDOG_DIS_BIT] |=> watchdog_enable) // see R11
    else $error("watchdog not enabled");

  a_mon_stop_off: assert property (@(posedge core_clk) disable iff (rst)
    in_stop && !word_one_q[wor_pkg::MON_IN_STOP_BIT] |=> !monitor_on) // see R12
    else $error("monitor on in stop without enable");

  a_mon_power: assert property (@(posedge core_clk) disable iff (rst)
    word_one_q[wor_pkg::MON_PWR_DIS_BIT] |=> !monitor_on) // see R14
    else $error("monitor on while powered down");

  a_vmode_out: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> monitor_5v_mode == $past(word_one_q[wor_pkg::MON_VMODE_BIT])) // see R15
    else $error("voltage mode output wrong");

  a_osc_out: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> osc_select == $past({word_two_q[wor_pkg::OSC_HIGH_BIT],
      word_two_q[wor_pkg::OSC_LOW_BIT]})) // see R16
    else $error("oscillator select wrong");

  a_int_func: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> int_pin_function_on == $past(word_two_q[wor_pkg::INT_FUNC_ON_BIT])) // see R17
    else $error("interrupt pin function wrong");

  a_pullup_out: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> int_pin_pullup_on == !$past(word_two_q[wor_pkg::INT_PULLUP_OFF_BIT])) // see R18
    else $error("interrupt pullup wrong");

  a_rstpin_out: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> reset_pin_function_on == $past(word_two_q[wor_pkg::RST_FUNC_ON_BIT])) // see R5
    else $error("reset pin function wrong");

endmodule

// >>> wor_pkg.sv
// package for the write-once option register bank
// assumes a wishbone classic slave with 8-bit data in the low lanes
package wor_pkg;

  // ********************************
  // register map (byte addresses)
  // ********************************
  localparam logic [7:0] OPT_TWO_ADDR = 8'h1e;
  localparam logic [7:0] OPT_ONE_ADDR = 8'h1f;
  localparam logic [7:0] STAT_ADDR    = 8'h20;

  // ********************************
  // option word one fields
  // ********************************
  localparam int WDOG_RATE_BIT    = 7;
  localparam int MON_IN_STOP_BIT  = 6;
  localparam int MON_RST_DIS_BIT  = 5;
  localparam int MON_PWR_DIS_BIT  = 4;
  localparam int MON_VMODE_BIT    = 3;
  localparam int SHORT_REC_BIT    = 2;
  localparam int STOP_EN_BIT      = 1;
  localparam int WDOG_DIS_BIT     = 0;

  // ********************************
  // option word two fields
  // ********************************
  localparam int INT_PULLUP_OFF_BIT = 7;
  localparam int INT_FUNC_ON_BIT    = 6;
  localparam int OSC_HIGH_BIT       = 1;
  localparam int OSC_LOW_BIT        = 0;
  localparam int RST_FUNC_ON_BIT    = 5;

  localparam logic [7:0] OPT_ONE_RESET = 8'h00;
  localparam logic [7:0] OPT_TWO_RESET = 8'h00;

  // ********************************
  // timing counts in oscillator cycles
  // ********************************
  localparam logic [17:0] WDOG_SHORT_CYC = 18'd8176;
  localparam logic [17:0] WDOG_LONG_CYC  = 18'd262128;
  localparam logic [14:0] WAKE_SHORT_CYC = 15'd512;
  localparam logic [14:0] WAKE_LONG_CYC  = 15'd16384;
  localparam logic [12:0] REC_SHORT_CYC  = 13'd32;
  localparam logic [12:0] REC_LONG_CYC   = 13'd4096;

endpackage

// >>> wor_option_regs_tb.sv
// self-checking bench for the write-once option register bank
// assumes a wishbone classic slave that acks one cycle after taking a request
`timescale 1ns/1ps

module wor_option_regs_tb;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        por = 1'b1;
  logic        in_stop = 1'b0;
  logic        wake_by_monitor = 1'b0;
  logic        monitor_reset_req = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic [17:0] wd_to;
  logic [14:0] wk_per;
  logic [12:0] rec;
  logic        stop_ill, wd_en, mon_on, mon_rst, mon_5v, int_on, pu_on, rst_on;
  logic [1:0]  osc;
  int          n_fail = 0;
  int          comparisons = 0;
  logic [31:0] r;

  always #2.5 core_clk = ~core_clk;

  wor_option_regs DUT (.core_clk(core_clk), .rst(rst), .por(por), .in_stop(in_stop),
    .wake_by_monitor(wake_by_monitor), .monitor_reset_req(monitor_reset_req),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .watchdog_timeout(wd_to),
    .wakeup_period(wk_per), .stop_recovery(rec), .stop_illegal(stop_ill),
    .watchdog_enable(wd_en), .monitor_on(mon_on), .monitor_reset(mon_rst),
    .monitor_5v_mode(mon_5v), .osc_select(osc), .int_pin_function_on(int_on),
    .int_pin_pullup_on(pu_on), .reset_pin_function_on(rst_on));

  // ********************************
  // bus and check tasks
  // ********************************
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'h1; wdat <= {24'h0, d};
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    r = rdat;
    if (n >= 20) chk(32'h1, 32'h0);
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic do_reset(input logic p);
    @(posedge core_clk);
    rst <= 1'b1; por <= p;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0; por <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic settle();
    repeat (3) @(posedge core_clk);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #20000;
    n_fail++;
    stop_test();
  end

  // ********************************
  // tests
  // ********************************
  initial
  begin
    do_reset(1'b1);
    chk(wd_to, wor_pkg::WDOG_LONG_CYC);
    chk(wk_per, wor_pkg::WAKE_LONG_CYC);
    chk(rec, wor_pkg::REC_LONG_CYC);
    chk({stop_ill, wd_en, pu_on, rst_on}, 4'b1110);
    xfer(8'h1f, 1'b0, 8'h00); chk(r, 32'h0);
    xfer(8'h1f, 1'b1, 8'had); xfer(8'h1f, 1'b1, 8'h52); settle();
    xfer(8'h1f, 1'b0, 8'h00); chk(r, 32'had);
    chk(wd_to, wor_pkg::WDOG_SHORT_CYC);
    chk(wk_per, wor_pkg::WAKE_SHORT_CYC);
    chk(rec, wor_pkg::REC_SHORT_CYC);
    chk({stop_ill, wd_en, mon_5v, mon_on}, 4'b1011);
    monitor_reset_req <= 1'b1; in_stop <= 1'b1; wake_by_monitor <= 1'b1; settle();
    chk({mon_rst, mon_on}, 2'b00);
    chk(rec, wor_pkg::REC_LONG_CYC);
    in_stop <= 1'b0; wake_by_monitor <= 1'b0;
    xfer(8'h1e, 1'b1, 8'he1); xfer(8'h1e, 1'b1, 8'h02); settle();
    xfer(8'h1e, 1'b0, 8'h00); chk(r, 32'he1);
    chk({pu_on, int_on, rst_on, osc}, 5'b01101);
    xfer(8'h40, 1'b1, 8'hff); xfer(8'h40, 1'b0, 8'h00); chk(r, 32'h0);
    xfer(8'h20, 1'b0, 8'h00); chk(r, 32'h3);
    $display("test first_writes done");
    do_reset(1'b0);
    xfer(8'h1f, 1'b0, 8'h00); chk(r, 32'h08);
    xfer(8'h1e, 1'b0, 8'h00); chk(r, 32'h20);
    chk({rst_on, mon_5v}, 2'b11);
    xfer(8'h1f, 1'b1, 8'h52); settle();
    xfer(8'h1f, 1'b0, 8'h00); chk(r, 32'h52);
    chk(wd_to, wor_pkg::WDOG_LONG_CYC);
    chk(wk_per, wor_pkg::WAKE_LONG_CYC);
    chk(rec, wor_pkg::REC_LONG_CYC);
    chk({stop_ill, wd_en, mon_on, mon_rst}, 4'b0101);
    monitor_reset_req <= 1'b0; settle();
    chk(mon_rst, 32'h0);
    $display("test warm_reset done");
    for (int i = 0; i < 4; i++)
    begin
      do_reset(1'b1);
      chk({rst_on, mon_5v}, 2'b00);
      xfer(8'h1e, 1'b1, i[7:0]); settle();
      chk(osc, i[1:0]);
    end
    do_reset(1'b1);
    xfer(8'h1f, 1'b1, 8'h40); settle();
    in_stop <= 1'b1; settle();
    chk(mon_on, 32'h1);
    in_stop <= 1'b0;
    $display("test osc_and_monitor done");
    stop_test();
  end
endmodule
